// *** src/ufil_core.sv ***
module ufil_core (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire ufil_pkg::ufil_bus_s bus,
  output logic [7:0] rd_data,
  // Serial and modem pins
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  output logic txd,
  // Mode strap and interrupt
  input wire logic compat_legacy_mode,
  output logic irq
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] frame_len(input logic [7:0] line_control);
    return 4'h7 + {2'h0, line_control[1:0]} + {3'h0, line_control[ufil_pkg::LCR_PEN]}
      + {3'h0, line_control[ufil_pkg::LCR_STB]};
  endfunction

  function automatic logic parity_of(input logic [7:0] d, input logic [7:0] line_control);
    logic p;
    p = ^(d & (8'hFF >> (2'h3 - line_control[1:0])));
    if (line_control[ufil_pkg::LCR_STICK])
      return ~line_control[ufil_pkg::LCR_EPS];
    return line_control[ufil_pkg::LCR_EPS] ? p : ~p;
  endfunction

  function automatic logic [11:0] tx_frame(input logic [7:0] d, input logic [7:0] line_control);
    logic [11:0] f;
    logic [3:0] nb;
    f = 12'hFFF;
    nb = 4'h5 + {2'h0, line_control[1:0]};
    for (int i = 0; i < 8; i++)
    begin
      if (i < int'(nb))
        f[i + 1] = d[i];
    end
    f[0] = 1'b0;
    if (line_control[ufil_pkg::LCR_PEN])
      f[nb + 4'h1] = parity_of(d, line_control);
    return f;
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers and baud enable
  // ---------------------------------------------------------------
  logic [5:0] pin_meta_ff;
  logic [5:0] pin_sync_ff;
  logic [15:0] baud_cnt_ff;
  logic [15:0] nxt_baud_cnt;
  logic tick;
  logic rx_s;
  logic xt_mode;
  logic [7:0] lcr_ff;
  logic [7:0] dll_ff;
  logic [7:0] dlm_ff;
  logic divisor_access_bit;

  assign rx_s = pin_sync_ff[0];
  assign xt_mode = pin_sync_ff[5];
  assign divisor_access_bit = lcr_ff[ufil_pkg::LCR_DIVISOR_ACCESS_BIT];
  assign tick = (baud_cnt_ff == 16'h0000);

  // The divisor counts core clocks, so all character timing scales with it.
  always_comb
  begin
    nxt_baud_cnt = baud_cnt_ff - 16'h0001;
    if (tick)
      nxt_baud_cnt = ({dlm_ff, dll_ff} == 16'h0000) ? 16'h0000 : {dlm_ff, dll_ff} - 16'h0001;
    if (bus.wr && divisor_access_bit && (bus.addr == ufil_pkg::ADDR_DATA || bus.addr == ufil_pkg::ADDR_IER))
      nxt_baud_cnt = 16'h0000;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_meta_ff <= 6'h1F;
      pin_sync_ff <= 6'h1F;
      baud_cnt_ff <= 16'h0000;
    end
    else
    begin
      pin_meta_ff <= {compat_legacy_mode, dcd_n, ri_n, dsr_n, cts_n, rxd};
      pin_sync_ff <= pin_meta_ff;
      baud_cnt_ff <= nxt_baud_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  ufil_pkg::ufil_state_e rx_state_ff, nxt_rx_state;
  logic [11:0] rx_bits_ff, nxt_rx_bits;
  logic [3:0] rx_bit_ff, nxt_rx_bit;
  logic [3:0] rx_tick_ff, nxt_rx_tick;
  logic rx_done;
  ufil_pkg::ufil_rx_s rx_word;

  always_comb
  begin
    logic [11:0] samp;
    logic [3:0] stop_idx;
    samp = rx_bits_ff;
    stop_idx = 4'h6 + {2'h0, lcr_ff[1:0]} + {3'h0, lcr_ff[ufil_pkg::LCR_PEN]};
    nxt_rx_state = rx_state_ff;
    nxt_rx_bits = rx_bits_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_tick = rx_tick_ff;
    rx_done = 1'b0;
    samp[rx_bit_ff] = rx_s;
    rx_word.data = samp[8:1] & (8'hFF >> (2'h3 - lcr_ff[1:0]));
    rx_word.pe = lcr_ff[ufil_pkg::LCR_PEN]
      && (samp[stop_idx - 4'h1] != parity_of(rx_word.data, lcr_ff));
    rx_word.fe = ~samp[stop_idx];
    rx_word.bi = ~|(samp & (12'hFFF >> (4'hB - stop_idx)));
    case (rx_state_ff)
      ufil_pkg::ST_IDLE:
      begin
        if (tick && !rx_s)
        begin
          nxt_rx_state = ufil_pkg::ST_RUN;
          nxt_rx_bit = 4'h0;
          nxt_rx_tick = 4'h0;
        end
      end
      ufil_pkg::ST_RUN:
      begin
        if (tick)
        begin
          nxt_rx_tick = rx_tick_ff + 4'h1;
          if (rx_tick_ff == ufil_pkg::TICK_MID)
          begin
            nxt_rx_bits = samp;
            nxt_rx_bit = rx_bit_ff + 4'h1;
            if ((rx_bit_ff == 4'h0 && rx_s) || rx_bit_ff == stop_idx)
              nxt_rx_state = ufil_pkg::ST_IDLE;
            rx_done = (rx_bit_ff == stop_idx);
          end
        end
      end
      default:
        nxt_rx_state = ufil_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_state_ff <= ufil_pkg::ST_IDLE;
      rx_bits_ff <= 12'hFFF;
      rx_bit_ff <= 4'h0;
      rx_tick_ff <= 4'h0;
    end
    else
    begin
      rx_state_ff <= nxt_rx_state;
      rx_bits_ff <= nxt_rx_bits;
      rx_bit_ff <= nxt_rx_bit;
      rx_tick_ff <= nxt_rx_tick;
    end
  end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  ufil_pkg::ufil_state_e tx_state_ff, nxt_tx_state;
  logic [11:0] tx_shift_ff, nxt_tx_shift;
  logic [3:0] tx_bit_ff, nxt_tx_bit;
  logic [3:0] tx_tick_ff, nxt_tx_tick;
  logic txd_ff;
  logic tx_pop;
  logic [4:0] tx_cnt_ff;
  logic [3:0] tx_rp_ff;
  logic [7:0] tx_mem [16];

  always_comb
  begin
    nxt_tx_state = tx_state_ff;
    nxt_tx_shift = tx_shift_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_tick = tx_tick_ff;
    tx_pop = 1'b0;
    case (tx_state_ff)
      ufil_pkg::ST_IDLE:
      begin
        if (tx_cnt_ff != 5'h00)
        begin
          tx_pop = 1'b1;
          nxt_tx_shift = tx_frame(tx_mem[tx_rp_ff], lcr_ff);
          nxt_tx_state = ufil_pkg::ST_RUN;
          nxt_tx_bit = 4'h0;
          nxt_tx_tick = 4'h0;
        end
      end
      ufil_pkg::ST_RUN:
      begin
        if (tick)
        begin
          nxt_tx_tick = tx_tick_ff + 4'h1;
          if (tx_tick_ff == ufil_pkg::TICK_LAST)
          begin
            nxt_tx_shift = {1'b1, tx_shift_ff[11:1]};
            nxt_tx_bit = tx_bit_ff + 4'h1;
            if (tx_bit_ff == frame_len(lcr_ff) - 4'h1)
              nxt_tx_state = ufil_pkg::ST_IDLE;
          end
        end
      end
      default:
        nxt_tx_state = ufil_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_state_ff <= ufil_pkg::ST_IDLE;
      tx_shift_ff <= 12'hFFF;
      tx_bit_ff <= 4'h0;
      tx_tick_ff <= 4'h0;
      txd_ff <= 1'b1;
    end
    else
    begin
      tx_state_ff <= nxt_tx_state;
      tx_shift_ff <= nxt_tx_shift;
      tx_bit_ff <= nxt_tx_bit;
      tx_tick_ff <= nxt_tx_tick;
      txd_ff <= nxt_tx_shift[0] & ~lcr_ff[ufil_pkg::LCR_BRK];
    end
  end

  assign txd = txd_ff;

  // ---------------------------------------------------------------
  // Registers, FIFOs and interrupt identity
  // ---------------------------------------------------------------
  ufil_pkg::ufil_rx_s rx_mem [16];
  logic [3:0] ier_ff, nxt_ier;
  logic [7:0] nxt_lcr, nxt_dll, nxt_dlm;
  logic [4:0] mcr_ff, nxt_mcr;
  logic [7:0] scr_ff, nxt_scr;
  logic fen_ff, nxt_fen;
  logic [1:0] trig_ff, nxt_trig;
  logic [7:0] rd_data_ff, nxt_rd_data;
  logic oe_ff, nxt_oe;
  logic lsi_ff, nxt_lsi;
  logic tx_holding_empty_ff, nxt_tx_holding_empty;
  logic two_ff, nxt_two;
  logic dly_on_ff, nxt_dly_on;
  logic [7:0] dly_ff, nxt_dly;
  logic [9:0] to_cnt_ff, nxt_to_cnt;
  logic to_ff, nxt_to;
  logic [3:0] rx_wp_ff, rx_rp_ff, tx_wp_ff;
  logic [4:0] rx_cnt_ff, nxt_rx_cnt, err_cnt_ff, nxt_err_cnt, nxt_tx_cnt;
  logic rx_wr, rx_rd, tx_wr, rx_clr, tx_clr;
  logic wr_thr, rd_rbr, rd_iir, wr_fcr;
  logic [3:0] iir_code;
  ufil_pkg::ufil_rx_s rx_head;

  assign rx_head = rx_mem[rx_rp_ff];
  assign wr_thr = bus.wr && bus.addr == ufil_pkg::ADDR_DATA && !divisor_access_bit;
  assign rd_rbr = bus.rd && bus.addr == ufil_pkg::ADDR_DATA && !divisor_access_bit;
  assign rd_iir = bus.rd && bus.addr == ufil_pkg::ADDR_IIR;
  assign wr_fcr = bus.wr && bus.addr == ufil_pkg::ADDR_IIR;
  // Outside FIFO mode the holding stage is one byte deep.
  assign rx_wr = rx_done && rx_cnt_ff < (fen_ff ? ufil_pkg::FIFO_DEPTH : 5'h01);
  assign rx_rd = rd_rbr && rx_cnt_ff != 5'h00;
  assign tx_wr = wr_thr && tx_cnt_ff < (fen_ff ? ufil_pkg::FIFO_DEPTH : 5'h01);
  assign rx_clr = wr_fcr && (bus.wdata[ufil_pkg::FCR_RXRST] || bus.wdata[0] != fen_ff);
  assign tx_clr = wr_fcr && (bus.wdata[ufil_pkg::FCR_TXRST] || bus.wdata[0] != fen_ff);

  always_comb
  begin
    logic lsi_int, to_int, rda_int, tx_holding_empty_int;
    lsi_int = lsi_ff && ier_ff[ufil_pkg::IER_LSI];
    to_int = to_ff && ier_ff[ufil_pkg::IER_RDA] && fen_ff;
    rda_int = ier_ff[ufil_pkg::IER_RDA]
      && (fen_ff ? rx_cnt_ff >= ufil_pkg::TRIG_LVL[trig_ff] : rx_cnt_ff != 5'h00);
    tx_holding_empty_int = tx_holding_empty_ff && ier_ff[ufil_pkg::IER_TX_HOLDING_EMPTY] && tx_cnt_ff == 5'h00;
    if (lsi_int)
      iir_code = ufil_pkg::IIR_LSI;
    else if (rda_int)
      iir_code = ufil_pkg::IIR_RDA;
    else if (to_int)
      iir_code = ufil_pkg::IIR_TO;
    else if (tx_holding_empty_int)
      iir_code = ufil_pkg::IIR_TX_HOLDING_EMPTY;
    else
      iir_code = ufil_pkg::IIR_NONE;
  end

  assign irq = (iir_code != ufil_pkg::IIR_NONE);

  always_comb
  begin
    logic [3:0] fl;
    fl = frame_len(lcr_ff);
    nxt_ier = ier_ff;
    nxt_lcr = lcr_ff;
    nxt_dll = dll_ff;
    nxt_dlm = dlm_ff;
    nxt_mcr = mcr_ff;
    nxt_scr = scr_ff;
    nxt_fen = fen_ff;
    nxt_trig = trig_ff;
    nxt_rd_data = rd_data_ff;
    nxt_oe = oe_ff;
    nxt_lsi = lsi_ff;
    nxt_tx_holding_empty = tx_holding_empty_ff;
    nxt_two = two_ff;
    nxt_dly_on = dly_on_ff;
    nxt_dly = dly_ff;
    nxt_to = to_ff;
    nxt_to_cnt = to_cnt_ff;
    if (bus.wr)
    begin
      case (bus.addr)
        ufil_pkg::ADDR_DATA:
        begin
          if (divisor_access_bit)
            nxt_dll = bus.wdata;
        end
        ufil_pkg::ADDR_IER:
        begin
          if (divisor_access_bit)
            nxt_dlm = bus.wdata;
          else
            nxt_ier = bus.wdata[3:0];
        end
        ufil_pkg::ADDR_IIR:
        begin
          // The DMA select bit is dropped on purpose.
          nxt_fen = bus.wdata[ufil_pkg::FCR_EN];
          nxt_trig = bus.wdata[7:6];
        end
        ufil_pkg::ADDR_LCR:
          nxt_lcr = bus.wdata;
        ufil_pkg::ADDR_MCR:
          nxt_mcr = bus.wdata[4:0];
        ufil_pkg::ADDR_SCR:
        begin
          if (!xt_mode)
            nxt_scr = bus.wdata;
        end
        default:
          nxt_scr = scr_ff;
      endcase
    end
    // Line status: a set in the same cycle as the clearing read wins.
    if (bus.rd && bus.addr == ufil_pkg::ADDR_LSR)
    begin
      nxt_oe = 1'b0;
      nxt_lsi = 1'b0;
    end
    if (rx_done && !rx_wr)
      nxt_oe = 1'b1;
    if ((rx_done && !rx_wr) || (rx_wr && (rx_word.pe || rx_word.fe || rx_word.bi)))
      nxt_lsi = 1'b1;
    // Transmit-empty: clears first, then the empty events set it.
    if (wr_thr || (rd_iir && iir_code == ufil_pkg::IIR_TX_HOLDING_EMPTY))
      nxt_tx_holding_empty = 1'b0;
    if (tick && dly_on_ff)
      nxt_dly = dly_ff - 8'h01;
    if (dly_on_ff && dly_ff == 8'h00)
    begin
      nxt_dly_on = 1'b0;
      nxt_tx_holding_empty = 1'b1;
    end
    nxt_tx_cnt = tx_clr ? 5'h00 : tx_cnt_ff + {4'h0, tx_wr} - {4'h0, tx_pop};
    if (nxt_tx_cnt >= 5'h02)
      nxt_two = 1'b1;
    if (tx_pop && tx_cnt_ff == 5'h01 && !tx_wr)
    begin
      nxt_two = 1'b0;
      if (two_ff)
        nxt_tx_holding_empty = 1'b1;
      else
      begin
        nxt_dly_on = 1'b1;
        nxt_dly = {fl - 4'h1, 4'h0};
      end
    end
    if (wr_fcr && bus.wdata[0] != fen_ff)
    begin
      nxt_tx_holding_empty = 1'b1;
      nxt_dly_on = 1'b0;
      nxt_two = 1'b0;
    end
    // Time-out timer runs on baud ticks; four frames include any second stop bit.
    if (rx_cnt_ff == 5'h00 || rx_clr || (to_ff ? rx_rd : (rx_wr || rd_rbr)))
    begin
      nxt_to_cnt = 10'h000;
      nxt_to = 1'b0;
    end
    else if (to_cnt_ff == {fl, 4'h0, ufil_pkg::TO_CHARS_LOG2 - 2'h2})
      nxt_to = 1'b1;
    else if (tick)
      nxt_to_cnt = to_cnt_ff + 10'h001;
    if (bus.rd)
    begin
      case (bus.addr)
        ufil_pkg::ADDR_DATA:
          nxt_rd_data = divisor_access_bit ? dll_ff : rx_head.data;
        ufil_pkg::ADDR_IER:
          nxt_rd_data = divisor_access_bit ? dlm_ff : {4'h0, ier_ff};
        ufil_pkg::ADDR_IIR:
          nxt_rd_data = {fen_ff, fen_ff, 2'h0, iir_code};
        ufil_pkg::ADDR_LCR:
          nxt_rd_data = lcr_ff;
        ufil_pkg::ADDR_MCR:
          nxt_rd_data = {3'h0, mcr_ff};
        ufil_pkg::ADDR_LSR:
          nxt_rd_data = {fen_ff && err_cnt_ff != 5'h00,
            tx_state_ff == ufil_pkg::ST_IDLE && (xt_mode || tx_cnt_ff == 5'h00),
            tx_cnt_ff == 5'h00,
            {rx_head.bi, rx_head.fe, rx_head.pe} & {3{rx_cnt_ff != 5'h00}},
            oe_ff,
            rx_cnt_ff != 5'h00};
        ufil_pkg::ADDR_MSR:
          nxt_rd_data = {~pin_sync_ff[4:1], 4'h0};
        default:
          nxt_rd_data = xt_mode ? ufil_pkg::REG_RESET : scr_ff;
      endcase
    end
    nxt_rx_cnt = rx_clr ? 5'h00 : rx_cnt_ff + {4'h0, rx_wr} - {4'h0, rx_rd};
    nxt_err_cnt = rx_clr ? 5'h00 : err_cnt_ff
      + {4'h0, rx_wr && (rx_word.pe || rx_word.fe || rx_word.bi)}
      - {4'h0, rx_rd && (rx_head.pe || rx_head.fe || rx_head.bi)};
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ier_ff <= 4'h0;
      lcr_ff <= ufil_pkg::REG_RESET;
      dll_ff <= ufil_pkg::REG_RESET;
      dlm_ff <= ufil_pkg::REG_RESET;
      mcr_ff <= 5'h00;
      scr_ff <= ufil_pkg::REG_RESET;
      fen_ff <= 1'b0;
      trig_ff <= 2'h0;
      rd_data_ff <= ufil_pkg::REG_RESET;
      oe_ff <= 1'b0;
      lsi_ff <= 1'b0;
      tx_holding_empty_ff <= 1'b0;
      two_ff <= 1'b0;
      dly_on_ff <= 1'b0;
      dly_ff <= 8'h00;
      to_ff <= 1'b0;
      to_cnt_ff <= 10'h000;
      rx_cnt_ff <= 5'h00;
      err_cnt_ff <= 5'h00;
      tx_cnt_ff <= 5'h00;
      rx_wp_ff <= 4'h0;
      rx_rp_ff <= 4'h0;
      tx_wp_ff <= 4'h0;
      tx_rp_ff <= 4'h0;
    end
    else
    begin
      ier_ff <= nxt_ier;
      lcr_ff <= nxt_lcr;
      dll_ff <= nxt_dll;
      dlm_ff <= nxt_dlm;
      mcr_ff <= nxt_mcr;
      scr_ff <= nxt_scr;
      fen_ff <= nxt_fen;
      trig_ff <= nxt_trig;
      rd_data_ff <= nxt_rd_data;
      oe_ff <= nxt_oe;
      lsi_ff <= nxt_lsi;
      tx_holding_empty_ff <= nxt_tx_holding_empty;
      two_ff <= nxt_two;
      dly_on_ff <= nxt_dly_on;
      dly_ff <= nxt_dly;
      to_ff <= nxt_to;
      to_cnt_ff <= nxt_to_cnt;
      rx_cnt_ff <= nxt_rx_cnt;
      err_cnt_ff <= nxt_err_cnt;
      tx_cnt_ff <= nxt_tx_cnt;
      rx_wp_ff <= rx_clr ? 4'h0 : rx_wp_ff + {3'h0, rx_wr};
      rx_rp_ff <= rx_clr ? 4'h0 : rx_rp_ff + {3'h0, rx_rd};
      tx_wp_ff <= tx_clr ? 4'h0 : tx_wp_ff + {3'h0, tx_wr};
      tx_rp_ff <= tx_clr ? 4'h0 : tx_rp_ff + {3'h0, tx_pop};
    end
  end

  // Storage only, so no reset: contents are qualified by the counts.
  always_ff @(posedge core_clk)
  begin
    if (rx_wr)
      rx_mem[rx_wp_ff] <= rx_word;
    if (tx_wr)
      tx_mem[tx_wp_ff] <= bus.wdata;
  end

  assign rd_data = rd_data_ff;
endmodule // ufil_core

// *** src/ufil_pkg.sv ***
package ufil_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_IIR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_SCR = 3'h7;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int LCR_STB = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EPS = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_BRK = 6;
  localparam int LCR_DIVISOR_ACCESS_BIT = 7;
  localparam int FCR_EN = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int IER_RDA = 0;
  localparam int IER_TX_HOLDING_EMPTY = 1;
  localparam int IER_LSI = 2;
  // ---------------------------------------------------------------
  // Identity codes, reset values and counts
  // ---------------------------------------------------------------
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_LSI = 4'h6;
  localparam logic [3:0] IIR_RDA = 4'h4;
  localparam logic [3:0] IIR_TO = 4'hC;
  localparam logic [3:0] IIR_TX_HOLDING_EMPTY = 4'h2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] TRIG_LVL [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [1:0] TO_CHARS_LOG2 = 2'h2;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_RUN} ufil_state_e;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ufil_bus_s;
  typedef struct packed {
    logic bi;
    logic fe;
    logic pe;
    logic [7:0] data;
  } ufil_rx_s;
endpackage

// *** sim/ufil_monitor.sv ***
module ufil_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire ufil_pkg::ufil_bus_s bus,
  input wire logic [7:0] rd_data,
  // Serial, modem and strap pins
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  input wire logic txd,
  input wire logic compat_legacy_mode,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Shadow registers
  // ---------------------------------------------------------------
  // Shadows follow host writes only, so a design register that never
  // updates, or is decoded at the wrong offset, shows up on readback.
  logic [7:0] lcr_ff;
  logic [7:0] ier_ff;
  logic [7:0] mcr_ff;
  logic rd_iir;
  logic rd_lsr;
  assign rd_iir = bus.rd && bus.addr == 3'h2;
  assign rd_lsr = bus.rd && bus.addr == 3'h5;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      lcr_ff <= 8'h00;
      ier_ff <= 8'h00;
      mcr_ff <= 8'h00;
    end
    else if (bus.wr)
    begin
      if (bus.addr == 3'h3)
        lcr_ff <= bus.wdata;
      if (bus.addr == 3'h4)
        mcr_ff <= bus.wdata;
      if (bus.addr == 3'h1 && !lcr_ff[7])
        ier_ff <= bus.wdata;
    end
  end
  iir_pend_a: assert property (
    rd_iir |=> rd_data[0] == !$past(irq) && rd_data[5:4] == 2'h0)
    else $error("iir pending bit wrong");
  iir_code_a: assert property (
    rd_iir |=> rd_data[3:0] inside {4'h1, 4'h2, 4'h4, 4'h6, 4'hC})
    else $error("iir code illegal");
  polled_quiet_a: assert property (
    ier_ff[3:0] == 4'h0 && $past(ier_ff[3:0]) == 4'h0 |-> !irq)
    else $error("irq in polled mode");
  ier_read_a: assert property (
    bus.rd && bus.addr == 3'h1 && !lcr_ff[7] |=> rd_data == {4'h0, ier_ff[3:0]})
    else $error("ier readback wrong");
  aux_store_a: assert property (
    bus.rd && bus.addr == 3'h4 |=> rd_data[3:0] == mcr_ff[3:0])
    else $error("mcr readback wrong");
  legacy_scr_a: assert property (
    bus.rd && bus.addr == 3'h7 && compat_legacy_mode && $past(compat_legacy_mode, 3)
    |=> rd_data == 8'h00)
    else $error("scratch visible in legacy mode");
  tx_holding_empty_clear_a: assert property (
    rd_iir ##1 rd_data[3:0] == 4'h2 |-> !irq)
    else $error("tx empty irq not cleared");
  transmitter_empty_tx_holding_empty_a: assert property (
    rd_lsr && !compat_legacy_mode && !$past(compat_legacy_mode, 3)
    |=> !rd_data[6] || rd_data[5])
    else $error("transmitter_empty without tx_holding_empty");
endmodule // ufil_monitor

bind ufil_core ufil_monitor u_mon (.core_clk, .rst, .bus, .rd_data, .rxd, .cts_n, .dsr_n,
  .ri_n, .dcd_n, .txd, .compat_legacy_mode, .irq);

// *** sim/ufil_serial_peer.sv ***
module ufil_serial_peer #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input wire logic core_clk,
  // Serial lines
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Remote serial peer
  // ---------------------------------------------------------------
  // The line idles high between frames; a stop level of zero makes a framing error.
  initial rxd = 1'b1;
  task automatic send_byte(input logic [7:0] b, input logic stop);
    logic [9:0] frm;
    frm = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= frm[i];
      repeat (BIT_CLKS) @(posedge core_clk);
    end
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge core_clk);
  endtask
  task automatic recv_byte(output logic [7:0] b);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 200)
    begin
      @(posedge core_clk);
      n++;
    end
    repeat (BIT_CLKS / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CLKS) @(posedge core_clk);
      b[i] = txd;
    end
    repeat (BIT_CLKS) @(posedge core_clk);
  endtask
endmodule // ufil_serial_peer

// *** sim/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic compat_legacy_mode = 1'b0;
  ufil_pkg::ufil_bus_s bus = '0;
  logic [7:0] rd_data;
  logic [7:0] v;
  logic rxd;
  logic txd;
  logic irq;
  int fail_count = 0;
  int checks = 0;
  always #2.5 core_clk = ~core_clk;
  ufil_core DUT (.core_clk, .rst, .bus, .rd_data, .rxd, .cts_n(1'b1), .dsr_n(1'b1),
    .ri_n(1'b1), .dcd_n(1'b1), .txd, .compat_legacy_mode, .irq);
  ufil_serial_peer peer (.core_clk, .txd, .rxd);
  // ---------------------------------------------------------------
  // Bus tasks and reporting
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    #1 d = rd_data;
  endtask
  task automatic rchk(input string name, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(name, d, exp);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    #1 check("txd", {7'h00, txd}, 8'h01);
    check("irq", {7'h00, irq}, 8'h00);
    rchk("iir", 3'h2, 8'h01);
    rchk("lsr", 3'h5, 8'h60);
    $display("test reset done");
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    rchk("dll", 3'h0, 8'h01);
    wr(3'h3, 8'h03);
    wr(3'h1, 8'h08);
    rchk("ier", 3'h1, 8'h08);
    wr(3'h4, 8'h0C);
    rchk("mcr", 3'h4, 8'h0C);
    wr(3'h7, 8'hA5);
    rchk("scr", 3'h7, 8'hA5);
    @(posedge core_clk);
    compat_legacy_mode <= 1'b1;
    repeat (4) @(posedge core_clk);
    rchk("scr", 3'h7, 8'h00);
    @(posedge core_clk);
    compat_legacy_mode <= 1'b0;
    $display("test registers done");
    // Trigger of four with the DMA bit set, which must change nothing.
    wr(3'h2, 8'h49);
    wr(3'h1, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        rchk("iir", 3'h2, 8'hC1);
      peer.send_byte(8'(8'h31 + i), 1'b1);
    end
    repeat (8) @(posedge core_clk);
    rchk("iir", 3'h2, 8'hC4);
    rchk("lsr", 3'h5, 8'h61);
    rchk("rbr", 3'h0, 8'h31);
    rchk("iir", 3'h2, 8'hC1);
    repeat (610) @(posedge core_clk);
    rchk("iir", 3'h2, 8'hC1);
    repeat (60) @(posedge core_clk);
    rchk("iir", 3'h2, 8'hCC);
    rchk("rbr", 3'h0, 8'h32);
    rchk("iir", 3'h2, 8'hC1);
    rchk("rbr", 3'h0, 8'h33);
    rchk("rbr", 3'h0, 8'h34);
    rchk("lsr", 3'h5, 8'h60);
    $display("test receive done");
    wr(3'h2, 8'h01);
    wr(3'h1, 8'h05);
    peer.send_byte(8'hF0, 1'b0);
    repeat (4) @(posedge core_clk);
    rchk("iir", 3'h2, 8'hC6);
    rd(3'h5, v);
    check("lsr err", {v[7], v[3], v[0], 5'h00}, 8'hE0);
    rchk("iir", 3'h2, 8'hC4);
    rd(3'h0, v);
    wr(3'h1, 8'h00);
    peer.send_byte(8'h3C, 1'b1);
    #1 check("irq", {7'h00, irq}, 8'h00);
    rchk("lsr", 3'h5, 8'h61);
    rchk("rbr", 3'h0, 8'h3C);
    $display("test status done");
    wr(3'h1, 8'h02);
    rchk("iir", 3'h2, 8'hC2);
    rchk("iir", 3'h2, 8'hC1);
    wr(3'h0, 8'hA5);
    rchk("lsr", 3'h5, 8'h20);
    rchk("iir", 3'h2, 8'hC1);
    peer.recv_byte(v);
    check("tx byte", v, 8'hA5);
    repeat (20) @(posedge core_clk);
    rchk("iir", 3'h2, 8'hC2);
    wr(3'h0, 8'h11);
    wr(3'h2, 8'h00);
    rchk("iir", 3'h2, 8'h02);
    $display("test transmit done");
    // Outside FIFO mode the holding stage is one deep, so the second byte overruns.
    peer.send_byte(8'h5A, 1'b1);
    peer.send_byte(8'hC3, 1'b1);
    rchk("lsr", 3'h5, 8'h63);
    rchk("rbr", 3'h0, 8'h5A);
    $display("test overrun done");
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    final_report();
  end
endmodule // tb_top
